//--- logic/ext_port_cfg.sv
// external memory port: configuration registers, bank decode, waitstates,
// packing, bus grant. assumes one requester at a time per internal bus.
// Functional notes
// - read waitstate count in bits 2-0 of each access control register
// - write waitstate count in bits 5-3 of each access control register
// - insert 0 to 7 access clock waitstates before completing an access
// - bits 7-6 pick ack only, waits only, both, or either termination
// - ack mode spends at least two waitstates; low ack stretches further
// - bits 10-8 divide peripheral clock by 1,2,4,8,16,32 for access clock
// - bit 11 holds write data one extra cycle after write strobe ends
// - two page registers hold lower page of banks 0,1 and 2,3
// - eight-bit lowest page per bank; defaults give 64 pages each
// - bank 0 starts at 0x1_0000, banks 1-3 follow; select asserted
// - interface bit 3 selects 16-bit bus, else 8-bit, for all spaces
// - interface bits 4,5 give write/read strobe polarity, 1 active low
// - status bit 3 picks 24 or 16 bit data words; fetches ignore it
// - pack words into successive transfers per bus width
// - interface bit 6 lets external dma split, freeing internal memory
// - bit 15 adds each select line into the composite select
// - interface bit 0 ignores bus and dma requests, keeping mastership
// - interface bit 1 delays request response by 16 cycles
// - interface bit 2 blocks writes to all access control registers
// - status bit 0 sends instruction fetches to boot space
// - status bit 1 sends program bus data to boot space
// - status bit 2 sends data bus data to boot space
// - redirected accesses drive boot select and leave bank selects idle
// - three internal buses share one external bus by arbitration
// - unpacking instructions adds one cycle per word
// - low request while idle: float bus and grant next cycle
//
// Implementation choices: the register offsets and strobed register access.
`timescale 1ns/1ps
`default_nettype none
module ext_port_cfg (
  // clock, reset, enable
  input wire logic REF_CLK,
  input wire logic RST,
  input wire logic CE,
  // register port
  input wire logic [3:0] REG_ADDR,
  input wire logic [15:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  output logic [15:0] REG_RDATA,
  // internal requests: instr, pm data, dm data
  input wire logic [2:0] REQ_VALID,
  input wire logic [2:0] REQ_WRITE,
  input wire logic [2:0] REQ_IO,
  input wire logic [23:0] REQ_ADDR,
  input wire logic [23:0] REQ_WDATA,
  input wire logic DMA_REQ,
  output logic [2:0] REQ_DONE,
  output logic [23:0] REQ_RDATA,
  output logic DMA_SPLIT,
  // external memory pins
  output logic [23:0] EXT_ADDR,
  output logic [15:0] EXT_DATA_OUT,
  input wire logic [15:0] EXT_DATA_IN,
  output logic EXT_BUS_OE_N,
  output logic EXT_RD,
  output logic EXT_WR,
  input wire logic EXT_ACK,
  output logic [3:0] bank_select_n,
  output logic boot_space_select_n,
  output logic io_space_select_n,
  output logic composite_select_out,
  // bus mastership
  input wire logic bus_request_in_n,
  output logic bus_grant_out_n,
  output logic bus_grant_hang_out_n
);
  import ext_port_pkg::*;

  typedef enum logic [2:0] {
    S_IDLE = 3'b000,
    S_STROBE = 3'b001,
    S_HOLD = 3'b010,
    S_NEXT = 3'b011,
    S_DONE = 3'b100,
    S_GRANT = 3'b101
  } state_t;

  state_t state;
  logic [15:0] access_ctl [0:5];
  logic [15:0] pages_first, pages_second, iface, mode;
  logic [5:0] tick;
  logic [1:0] rr;
  logic [1:0] cur;
  logic [2:0] space;
  logic [23:0] addr, wdata, rdata;
  logic is_write;
  logic [1:0] beat, last_beat;
  logic [2:0] wait_cnt;
  logic [4:0] holdoff;
  logic [15:0] ctl;
  logic [1:0] grant_idx;
  logic grant_ok;
  logic [2:0] next_space;
  logic [7:0] page;
  // termination terms, read by the sequencer below
  logic term, count_met;
  logic [2:0] need;

  // register writes; access control writes blocked while locked
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      for (int i = 0; i < 6; i++) access_ctl[i] <= ACCESS_CTL_RESET;
      pages_first <= PAGES_FIRST_RESET;
      pages_second <= PAGES_SECOND_RESET;
      iface <= IFACE_RESET;
      mode <= 16'h0_000;
    end else if (CE && REG_WR) begin
      if (REG_ADDR <= A_IO_CTL && !iface[CRL_BIT])
        access_ctl[REG_ADDR[2:0]] <= REG_WDATA & ACCESS_CTL_MASK;
      if (REG_ADDR == A_PAGES_FIRST) pages_first <= REG_WDATA;
      if (REG_ADDR == A_PAGES_SECOND) pages_second <= REG_WDATA;
      if (REG_ADDR == A_IFACE_CTL) iface <= REG_WDATA & IFACE_MASK;
      if (REG_ADDR == A_MODE_STATUS) mode <= REG_WDATA & MODE_MASK;
    end
  end

  // read data one cycle after the strobe, zero otherwise and when unmapped
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      REG_RDATA <= 16'h0_000;
    end else if (CE) begin
      REG_RDATA <= 16'h0_000;
      if (REG_RD) begin
        if (REG_ADDR <= A_IO_CTL) REG_RDATA <= access_ctl[REG_ADDR[2:0]];
        else if (REG_ADDR == A_PAGES_FIRST) REG_RDATA <= pages_first;
        else if (REG_ADDR == A_PAGES_SECOND) REG_RDATA <= pages_second;
        else if (REG_ADDR == A_IFACE_CTL) REG_RDATA <= iface;
        else if (REG_ADDR == A_MODE_STATUS)
          REG_RDATA <= mode | (16'(state != S_IDLE) << BUSY_BIT) | (16'(state == S_GRANT) << GRANT_BIT);
      end
    end
  end

  // one divided access clock per bank and space
  genvar g;
  generate
    for (g = 0; g < 6; g++) begin : g_div
      access_clock_div u_div (
        .clk(REF_CLK),
        .rst(RST),
        .ce(CE),
        .divide(access_ctl[g][CDS_LSB +: 3]),
        .tick(tick[g])
      );
    end
  endgenerate

  // round robin over three buses; dma takes no slot in it
  always_comb begin
    grant_idx = rr;
    grant_ok = 1'b0;
    for (int k = 2; k >= 0; k--) begin
      if (REQ_VALID[2'((32'(rr) + k) % 3)]) begin
        grant_idx = 2'((32'(rr) + k) % 3);
        grant_ok = 1'b1;
      end
    end
  end

  // bank decode: highest of banks 1-3 whose lower page is not above the address page, else bank 0
  always_comb begin
    page = REQ_ADDR[23:16];
    next_space = 3'h0;
    if (page >= pages_first[15:8]) next_space = 3'h1;
    if (page >= pages_second[7:0]) next_space = 3'h2;
    if (page >= pages_second[15:8]) next_space = 3'h3;
    if (REQ_IO[grant_idx]) next_space = SP_IO;
    else if ((grant_idx == REQ_INSTR && mode[PI_BE_BIT]) ||
             (grant_idx == REQ_PDATA && mode[PD_BE_BIT]) ||
             (grant_idx == REQ_DDATA && mode[DD_BE_BIT]))
      next_space = SP_BOOT;
  end

  assign ctl = access_ctl[space];

  // holdoff counter for bus requests
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      holdoff <= 5'h0;
    end else if (CE) begin
      if (bus_request_in_n || !iface[BHE_BIT]) holdoff <= 5'h0;
      else if (holdoff != HOLDOFF_CYCLES) holdoff <= holdoff + 5'h1;
    end
  end

  // access sequencer
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      state <= S_IDLE;
      rr <= 2'h0;
      cur <= 2'h0;
      space <= 3'h0;
      addr <= 24'h0;
      wdata <= 24'h0;
      rdata <= 24'h0;
      is_write <= 1'b0;
      beat <= 2'h0;
      last_beat <= 2'h0;
      wait_cnt <= 3'h0;
    end else if (CE) begin
      case (state)
        S_IDLE: begin
          if (!bus_request_in_n && !iface[BL_BIT] &&
              (!iface[BHE_BIT] || holdoff == HOLDOFF_CYCLES)) begin
            state <= S_GRANT;
          end else if (grant_ok) begin
            cur <= grant_idx;
            rr <= (rr == 2'h2) ? 2'h0 : rr + 2'h1;
            space <= next_space;
            addr <= REQ_ADDR;
            wdata <= REQ_WDATA;
            rdata <= 24'h0;
            is_write <= REQ_WRITE[grant_idx];
            beat <= 2'h0;
            // 24-bit when instruction or format bit set; beats per bus width
            if (grant_idx == REQ_INSTR || mode[DFS_BIT])
              last_beat <= iface[BWS_BIT] ? 2'h1 : 2'h2;
            else
              last_beat <= iface[BWS_BIT] ? 2'h0 : 2'h1;
            wait_cnt <= 3'h0;
            state <= S_STROBE;
          end
        end
        S_STROBE: begin
          // count waits on the bank's own divided tick
          if (tick[space] && wait_cnt != 3'h7) wait_cnt <= wait_cnt + 3'h1;
          if (term) begin
            if (!is_write) begin
              if (iface[BWS_BIT]) rdata[beat*16 +: 8] <= EXT_DATA_IN[7:0];
              else rdata[beat*8 +: 8] <= EXT_DATA_IN[7:0];
              if (iface[BWS_BIT] && beat == 2'h0) rdata[15:8] <= EXT_DATA_IN[15:8];
            end
            state <= (is_write && ctl[WHE_BIT]) ? S_HOLD : S_NEXT;
          end
        end
        S_HOLD: state <= S_NEXT;
        S_NEXT: begin
          wait_cnt <= 3'h0;
          if (beat == last_beat) begin
            state <= S_DONE;
          end else begin
            beat <= beat + 2'h1;
            state <= S_STROBE;
          end
        end
        S_DONE: state <= S_IDLE;
        S_GRANT: if (bus_request_in_n) state <= S_IDLE;
        default: state <= S_IDLE;
      endcase
    end
  end

  // termination by waitstate mode
  always_comb begin
    need = is_write ? ctl[WWC_LSB +: 3] : ctl[RWC_LSB +: 3];
    count_met = wait_cnt >= need;
    case (wait_mode_t'(ctl[WMS_LSB +: 2]))
      WM_ACK: term = EXT_ACK && wait_cnt >= ACK_MIN_WAITS;
      WM_WAIT: term = count_met;
      WM_BOTH: term = EXT_ACK && count_met;
      WM_EITHER: term = EXT_ACK || count_met;
      default: term = count_met;
    endcase
    term = term && tick[space];
  end

  // pins; bank, boot and io selects active low, composite select active high, strobes per polarity bits
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      EXT_ADDR <= 24'h0;
      EXT_DATA_OUT <= 16'h0_000;
      bank_select_n <= 4'hF;
      boot_space_select_n <= 1'b1;
      io_space_select_n <= 1'b1;
      composite_select_out <= 1'b0;
      EXT_RD <= 1'b0;
      EXT_WR <= 1'b0;
      EXT_BUS_OE_N <= 1'b1;
      bus_grant_out_n <= 1'b1;
      REQ_DONE <= 3'h0;
      REQ_RDATA <= 24'h0;
    end else if (CE) begin
      EXT_ADDR <= addr + 24'(beat);
      EXT_DATA_OUT <= iface[BWS_BIT] ? wdata[beat*16 +: 16] : {8'h0, wdata[beat*8 +: 8]};
      bank_select_n <= 4'hF;
      boot_space_select_n <= 1'b1;
      io_space_select_n <= 1'b1;
      composite_select_out <= 1'b0;
      if (state == S_STROBE || state == S_HOLD) begin
        if (space == SP_BOOT) boot_space_select_n <= 1'b0;
        else if (space == SP_IO) io_space_select_n <= 1'b0;
        else bank_select_n[space[1:0]] <= 1'b0;
        composite_select_out <= ctl[COE_BIT];
      end
      EXT_RD <= iface[RLS_BIT] ^ (state == S_STROBE && !is_write);
      EXT_WR <= iface[WLS_BIT] ^ (state == S_STROBE && is_write);
      EXT_BUS_OE_N <= !(state == S_STROBE || state == S_HOLD) || !is_write;
      bus_grant_out_n <= !(state == S_GRANT);
      REQ_DONE <= (state == S_DONE) ? (3'h1 << cur) : 3'h0;
      if (state == S_DONE) REQ_RDATA <= rdata;
    end
  end

  // dma split and pending-request hang indication
  assign DMA_SPLIT = DMA_REQ && iface[ASE_BIT] && !iface[BL_BIT];
  assign bus_grant_hang_out_n = !(state == S_GRANT && grant_ok);
endmodule : ext_port_cfg
`default_nettype wire

//--- logic/ext_port_pkg.sv
// package for the external memory port configuration block
// holds register indices, field positions, reset values and timing counts
package ext_port_pkg;
  // register indices on the plain register port
  localparam logic [3:0] A_BANK0_CTL = 4'h0;
  localparam logic [3:0] A_BANK3_CTL = 4'h3;
  localparam logic [3:0] A_BOOT_CTL = 4'h4;
  localparam logic [3:0] A_IO_CTL = 4'h5;
  localparam logic [3:0] A_PAGES_FIRST = 4'h6;
  localparam logic [3:0] A_PAGES_SECOND = 4'h7;
  localparam logic [3:0] A_IFACE_CTL = 4'h8;
  localparam logic [3:0] A_MODE_STATUS = 4'h9;
  // access control fields
  localparam int RWC_LSB = 0;
  localparam int WWC_LSB = 3;
  localparam int WMS_LSB = 6;
  localparam int CDS_LSB = 8;
  localparam int WHE_BIT = 11;
  localparam int COE_BIT = 15;
  localparam logic [15:0] ACCESS_CTL_MASK = 16'h8F_FF;
  localparam logic [15:0] ACCESS_CTL_RESET = 16'h0_03F;
  // interface control bits
  localparam int BL_BIT = 0;
  localparam int BHE_BIT = 1;
  localparam int CRL_BIT = 2;
  localparam int BWS_BIT = 3;
  localparam int WLS_BIT = 4;
  localparam int RLS_BIT = 5;
  localparam int ASE_BIT = 6;
  localparam logic [15:0] IFACE_MASK = 16'h0_07F;
  localparam logic [15:0] IFACE_RESET = 16'h0_030;
  // mode/status bits
  localparam int PI_BE_BIT = 0;
  localparam int PD_BE_BIT = 1;
  localparam int DD_BE_BIT = 2;
  localparam int DFS_BIT = 3;
  localparam int BUSY_BIT = 8;
  localparam int GRANT_BIT = 9;
  localparam logic [15:0] MODE_MASK = 16'h0_00F;
  // default page boundaries: 64 pages per bank, bank 0 at page 0x01
  localparam logic [15:0] PAGES_FIRST_RESET = 16'h4_101;
  localparam logic [15:0] PAGES_SECOND_RESET = 16'hC_181;
  // waitstate modes
  typedef enum logic [1:0] {
    WM_ACK = 2'b00,
    WM_WAIT = 2'b01,
    WM_BOTH = 2'b10,
    WM_EITHER = 2'b11
  } wait_mode_t;
  localparam logic [2:0] ACK_MIN_WAITS = 3'h2;
  localparam logic [2:0] CDS_MAX = 3'h5;
  // request holdoff, in clock cycles
  localparam logic [4:0] HOLDOFF_CYCLES = 5'h10;
  // requester codes
  localparam logic [1:0] REQ_INSTR = 2'h0;
  localparam logic [1:0] REQ_PDATA = 2'h1;
  localparam logic [1:0] REQ_DDATA = 2'h2;
  localparam logic [1:0] REQ_DMA = 2'h3;
  // space codes
  localparam logic [2:0] SP_BOOT = 3'h4;
  localparam logic [2:0] SP_IO = 3'h5;
endpackage : ext_port_pkg

//--- logic/access_clock_div.sv
// divided access clock enable for one bank or space
// assumes the divider field is stable during an access
`timescale 1ns/1ps
`default_nettype none
module access_clock_div (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // control
  input wire logic [2:0] divide,
  // one-cycle tick at the divided rate
  output logic tick
);
  import ext_port_pkg::*;
  logic [4:0] count;
  logic [4:0] limit;

  // limit is 2^divide - 1; codes above 101 clamp to the slowest ratio
  always_comb begin
    limit = 5'(({1'b0, 5'h1} << ((divide > CDS_MAX) ? CDS_MAX : divide)) - 6'h1);
  end

  // free-running count, restarts at limit
  always_ff @(posedge clk) begin
    if (rst) begin
      count <= 5'h0;
    end else if (ce) begin
      count <= (count >= limit) ? 5'h0 : count + 5'h1;
    end
  end

  assign tick = ce && (count >= limit);
endmodule : access_clock_div
`default_nettype wire

//--- tb/ext_port_monitor.sv
// port checker for ext_port_cfg: selects, done pulses, grant, read port
// assumes one clock REF_CLK and sync reset RST; bound after endmodule
`timescale 1ns/1ps
`default_nettype none
module ext_port_monitor (
  // clock and reset
  input wire logic REF_CLK,
  input wire logic RST,
  // register and request side
  input wire logic REG_RD,
  input wire logic [15:0] REG_RDATA,
  input wire logic [2:0] REQ_VALID,
  input wire logic [2:0] REQ_DONE,
  input wire logic DMA_REQ,
  input wire logic DMA_SPLIT,
  // external side
  input wire logic EXT_BUS_OE_N,
  input wire logic [3:0] bank_select_n,
  input wire logic boot_space_select_n,
  input wire logic io_space_select_n,
  input wire logic composite_select_out,
  input wire logic bus_grant_out_n
);
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (RST);
  // read data stands only in the cycle after a read strobe
  a_rdata_idle_zero: assert property (!$past(REG_RD) |-> REG_RDATA == 16'h0000)
    else $error("read data not zero outside read cycle");
  a_bank_sel_one: assert property ($onehot0(~bank_select_n))
    else $error("more than one bank select");
  a_boot_no_bank: assert property (!boot_space_select_n |-> &bank_select_n)
    else $error("bank select beside boot select");
  a_grant_floats: assert property (!bus_grant_out_n |-> EXT_BUS_OE_N && &bank_select_n && boot_space_select_n)
    else $error("bus driven while granted");
  a_done_one_bus: assert property ($onehot0(REQ_DONE))
    else $error("two buses done at once");
  // a done pulse lasts one cycle and needs a held request behind it
  a_done_pulse_once: assert property (|REQ_DONE |=> (REQ_DONE & $past(REQ_DONE)) == 3'h0)
    else $error("done held longer than one cycle");
  a_done_has_req: assert property (|REQ_DONE |-> (REQ_DONE & ~$past(REQ_VALID)) == 3'h0)
    else $error("done without request");
  a_split_needs_dma: assert property (DMA_SPLIT |-> DMA_REQ)
    else $error("split without dma request");
  a_comp_has_sel: assert property (composite_select_out |->
    !(&bank_select_n && boot_space_select_n && io_space_select_n))
    else $error("composite select with no select low");
  c_grant: cover property (!bus_grant_out_n);
  c_boot: cover property (!boot_space_select_n);
  c_done: cover property (|REQ_DONE);
endmodule : ext_port_monitor
bind ext_port_cfg ext_port_monitor i_ext_port_monitor (.REF_CLK(REF_CLK), .RST(RST), .REG_RD(REG_RD),
  .REG_RDATA(REG_RDATA), .REQ_VALID(REQ_VALID), .REQ_DONE(REQ_DONE), .DMA_REQ(DMA_REQ),
  .DMA_SPLIT(DMA_SPLIT), .EXT_BUS_OE_N(EXT_BUS_OE_N), .bank_select_n(bank_select_n),
  .boot_space_select_n(boot_space_select_n), .io_space_select_n(io_space_select_n),
  .composite_select_out(composite_select_out), .bus_grant_out_n(bus_grant_out_n));
`default_nettype wire

//--- tb/ext_mem_model.sv
// behavioural asynchronous memory, 256 halfwords, behind the port pins
// assumes strobe polarity fixed by ACT_LOW; acks two cycles into a strobe
`timescale 1ns/1ps
`default_nettype none
module ext_mem_model #(parameter logic ACT_LOW = 1'b1) (
  // clock
  input wire logic clk,
  // pins from the port
  input wire logic [23:0] addr,
  input wire logic [15:0] wdata,
  input wire logic rd,
  input wire logic wr,
  input wire logic oe_n,
  // answers
  output logic [15:0] rdata,
  output logic ack
);
  logic [15:0] mem [0:255];
  logic [1:0] age;
  logic [7:0] churn = 8'h00;
  wire logic rd_on = rd ^ ACT_LOW;
  wire logic wr_on = wr ^ ACT_LOW;
  // store while the write strobe is active and the port drives data
  always @(posedge clk) begin
    if (wr_on && !oe_n) mem[addr[7:0]] <= wdata;
    age <= (rd_on || wr_on) ? ((age == 2'h3) ? age : age + 2'h1) : 2'h0;
    churn <= churn + 8'h01;
  end
  // released data lines churn so a stale value is never read as good
  assign rdata = rd_on ? mem[addr[7:0]] : {churn, ~churn};
  assign ack = (age >= 2'h2);
endmodule : ext_mem_model
`default_nettype wire

//--- tb/tb.sv
// self-checking bench for ext_port_cfg with an external memory model
// one 200 MHz clock; CE and REQ_IO are tied, everything else is driven
`timescale 1ns/1ps
`default_nettype none
module tb;
  import ext_port_pkg::*;
  logic REF_CLK = 1'b0, RST = 1'b1, REG_WR = 1'b0, REG_RD = 1'b0, DMA_REQ = 1'b0, req_n = 1'b1;
  logic [3:0] REG_ADDR = 4'h0, bank_n, bank_seen;
  logic [15:0] REG_WDATA = 16'h0000, REG_RDATA, ext_din, ext_dout, rd_val;
  logic [2:0] REQ_VALID = 3'h0, REQ_WRITE = 3'h0, REQ_DONE;
  logic [23:0] REQ_ADDR = 24'h00_0000, REQ_WDATA = 24'h00_0000, REQ_RDATA, EXT_ADDR, got;
  logic EXT_BUS_OE_N, EXT_RD, EXT_WR, DMA_SPLIT, boot_n, io_n, comp, grant_n, ack, boot_seen;
  int miscompares = 0, compares = 0, n;
  ext_port_cfg i_ext_port_cfg (.REF_CLK(REF_CLK), .RST(RST), .CE(1'b1), .REG_ADDR(REG_ADDR),
    .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .REQ_VALID(REQ_VALID),
    .REQ_WRITE(REQ_WRITE), .REQ_IO(3'h0), .REQ_ADDR(REQ_ADDR), .REQ_WDATA(REQ_WDATA), .DMA_REQ(DMA_REQ),
    .REQ_DONE(REQ_DONE), .REQ_RDATA(REQ_RDATA), .DMA_SPLIT(DMA_SPLIT), .EXT_ADDR(EXT_ADDR),
    .EXT_DATA_OUT(ext_dout), .EXT_DATA_IN(ext_din), .EXT_BUS_OE_N(EXT_BUS_OE_N), .EXT_RD(EXT_RD),
    .EXT_WR(EXT_WR), .EXT_ACK(ack), .bank_select_n(bank_n), .boot_space_select_n(boot_n),
    .io_space_select_n(io_n), .composite_select_out(comp), .bus_request_in_n(req_n),
    .bus_grant_out_n(grant_n), .bus_grant_hang_out_n());
  ext_mem_model i_ext_mem_model (.clk(REF_CLK), .addr(EXT_ADDR), .wdata(ext_dout), .rd(EXT_RD),
    .wr(EXT_WR), .oe_n(EXT_BUS_OE_N), .rdata(ext_din), .ack(ack));
  // 5 ns period
  always #2.5 REF_CLK = ~REF_CLK;
  task automatic check(input string what, input logic [23:0] seen, input logic [23:0] exp);
    compares++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic finish_test;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : finish_test
  task automatic reg_wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge REF_CLK);
    REG_ADDR <= a;
    REG_WDATA <= d;
    REG_WR <= 1'b1;
    @(posedge REF_CLK);
    REG_WR <= 1'b0;
  endtask : reg_wr
  task automatic reg_rd(input logic [3:0] a);
    @(posedge REF_CLK);
    REG_ADDR <= a;
    REG_RD <= 1'b1;
    @(posedge REF_CLK);
    REG_RD <= 1'b0;
    #1 rd_val = REG_RDATA;
  endtask : reg_rd
  // one request held until its done pulse; bank and boot selects seen low are recorded
  task automatic access(input int b, input logic w, input logic [23:0] a, input logic [23:0] d);
    @(posedge REF_CLK);
    REQ_VALID[b] <= 1'b1;
    REQ_WRITE[b] <= w;
    REQ_ADDR <= a;
    REQ_WDATA <= d;
    bank_seen = 4'hF;
    boot_seen = 1'b1;
    for (n = 0; n < 3000; n++) begin
      @(posedge REF_CLK);
      #1 bank_seen &= bank_n;
      boot_seen &= boot_n;
      if (REQ_DONE[b] === 1'b1) break;
    end
    check("done", REQ_DONE[b], 1'b1);
    got = REQ_RDATA;
    REQ_VALID[b] <= 1'b0;
  endtask : access
  task automatic t_regs;
    for (int i = 0; i < 6; i++) begin
      reg_rd(4'(i));
      check("access ctl reset", rd_val, ACCESS_CTL_RESET);
    end
    reg_rd(A_PAGES_FIRST);
    check("pages first", rd_val, PAGES_FIRST_RESET);
    reg_rd(A_PAGES_SECOND);
    check("pages second", rd_val, PAGES_SECOND_RESET);
    reg_rd(A_IFACE_CTL);
    check("iface reset", rd_val, IFACE_RESET);
    check("read strobe idle", EXT_RD, 1'b1);
    check("write strobe idle", EXT_WR, 1'b1);
    reg_rd(4'hA);
    check("unmapped", rd_val, 16'h0000);
    reg_wr(A_BOOT_CTL, 16'hFFFF);
    reg_wr(A_IFACE_CTL, 16'h0034);
    reg_wr(A_BOOT_CTL, 16'h0000);
    reg_rd(A_BOOT_CTL);
    check("locked ctl", rd_val, ACCESS_CTL_MASK);
    reg_wr(A_IFACE_CTL, 16'h0030);
    $display("regs done");
  endtask : t_regs
  task automatic t_access;
    reg_wr(A_BANK0_CTL, 16'h004A);
    reg_wr(A_IFACE_CTL, 16'h0038);
    access(2, 1'b1, 24'h01_0010, 24'h00_A5C3);
    check("bank0 select", bank_seen, 4'hE);
    access(2, 1'b0, 24'h01_0010, 24'h00_0000);
    check("16b readback", got[15:0], 16'hA5C3);
    reg_wr(A_IFACE_CTL, 16'h0030);
    access(2, 1'b1, 24'h01_0040, 24'h00_5A3C);
    access(2, 1'b0, 24'h01_0040, 24'h00_0000);
    check("8b readback", got[15:0], 16'h5A3C);
    reg_wr(A_PAGES_FIRST, 16'h0201);
    access(1, 1'b0, 24'h02_0000, 24'h00_0000);
    check("bank1 select", bank_seen, 4'hD);
    $display("access done");
  endtask : t_access
  task automatic t_boot;
    for (int b = 0; b < 3; b++) begin
      reg_wr(A_MODE_STATUS, 16'h0001 << b);
      access(b, 1'b0, 24'h01_0020, 24'h00_0000);
      check("boot select", boot_seen, 1'b0);
      check("no bank", bank_seen, 4'hF);
    end
    reg_wr(A_MODE_STATUS, 16'h0000);
    $display("boot done");
  endtask : t_boot
  task automatic t_grant;
    reg_wr(A_IFACE_CTL, 16'h0070);
    DMA_REQ <= 1'b1;
    req_n <= 1'b0;
    // request taken at the first edge, grant pin registered at the second
    repeat (2) @(posedge REF_CLK);
    #1 check("split", DMA_SPLIT, 1'b1);
    check("grant", grant_n, 1'b0);
    req_n <= 1'b1;
    reg_wr(A_IFACE_CTL, 16'h0071);
    req_n <= 1'b0;
    repeat (20) @(posedge REF_CLK);
    #1 check("locked grant", grant_n, 1'b1);
    check("locked split", DMA_SPLIT, 1'b0);
    req_n <= 1'b1;
    reg_wr(A_IFACE_CTL, 16'h0072);
    req_n <= 1'b0;
    for (n = 1; n < 40; n++) begin
      @(posedge REF_CLK);
      #1 if (grant_n === 1'b0) break;
    end
    check("holdoff", (n >= 16 && n <= 18), 1'b1);
    req_n <= 1'b1;
    DMA_REQ <= 1'b0;
    $display("grant done");
  endtask : t_grant
  // watchdog sized well past the expected run of a few hundred cycles
  initial begin
    #400000;
    miscompares++;
    finish_test();
  end
  // main sequence
  initial begin
    repeat (6) @(posedge REF_CLK);
    RST <= 1'b0;
    t_regs();
    t_access();
    t_boot();
    t_grant();
    finish_test();
  end
endmodule : tb
`default_nettype wire
